// ===== rtl/power_monitor_control.sv
// power monitor control: power-on flag, keyed disable, brown-out control and filtering
`timescale 1ns/1ns
`default_nettype none

// Function
// - power-on flag set by power-on reset, kept over brown-out reset, cleared by reset_in or software
// - power-on reset disabled by key 5a then a5 as consecutive writes
// - each key write needs the aa,55 timed-access unlock first
// - trip level from config bits 5:4, later overwritable at run time
// - detector result ignored for 2 to 3 slow oscillator cycles after enable
// - with reset disabled, drop below level sets event flag and interrupt request
// - event flag set only on crossing, not re-set while staying low
// - event flag also set when supply recovers above level
// - read-only level status shows supply currently below level
// - with reset enabled, drop causes reset and sets brown-out reset flag
// - reset flag cleared by both reset_in and power-on reset, software clears
// - first brown-out control register writes need timed-access unlock
// - low-power mode samples detector every 1.6, 6.4 or 25.6 ms
// - filter enabled after reset, writing 0 bypasses it except in power-down
// - config detect enable switches detection, config default all ones
// - config reset enable chooses reset or interrupt at power-up
// - power-on and brown-out reset load detect enable, level, reset enable from config, reset_in loads the all-ones default
// - sampling select 00 normal, 01/10/11 the three sampling periods
// - filter counts 32 system clocks fast normal, else 2 slow clocks
// - level status reads 0 while detection is disabled
module power_monitor_control
    import power_monitor_pkg::*;
(
    input  wire logic        clock_in,
    input  wire logic        reset_in,
    input  wire logic        power_on_reset_in,
    input  wire logic        slow_osc_tick_in,
    input  wire logic        fast_clock_source_in,
    input  wire logic        power_down_in,
    input  wire logic        supply_below_in,
    input  wire logic [7:0]  boot_config_in,
    input  wire reg_access_t reg_in,
    output logic      [7:0]  rdata_out,
    output logic             por_enable_out,
    output logic             brownout_irq_out,
    output logic             brownout_reset_out,
    output logic             detector_power_out,
    output logic      [1:0]  trip_level_out
);

    typedef struct packed {
        logic [7:0] rdata;
        logic       power_on_flag;
        logic       por_en;
        logic       por_armed;
        logic       ta_stage;
        logic [2:0] ta_count;
        logic       ta_open;
        logic       den;
        logic [1:0] lvl;
        logic       brownout_event_flag;
        logic       rst_en;
        logic       brownout_reset_flag;
        logic       brownout_level_status;
        logic [1:0] lp_sel;
        logic       flt;
        logic [1:0] settle;
        logic [5:0] flt_count;
        logic       filtered;
        logic       sampled;
        logic [7:0] lp_count;
        logic       sample_now;
        logic       irq;
        logic       bo_reset;
        logic       reset_pending;
    } state_t;

    state_t s_q;
    state_t s_d;

    logic       wr_ta;
    logic       wr_c0;
    logic       wr_c1;
    logic       wr_power_control_flags;
    logic       wr_por;
    logic       protected_wr;
    logic       raw_level;
    logic [5:0] flt_limit;
    logic       flt_step;
    logic [7:0] lp_limit;
    logic       valid;
    logic       prev_level;

    // ******************************
    // address decode
    // ******************************
    always_comb begin
        wr_ta   = 1'b0;
        wr_c0   = 1'b0;
        wr_c1   = 1'b0;
        wr_power_control_flags = 1'b0;
        wr_por  = 1'b0;
        if (reg_in.addr == addr_timed_access_key) begin
            wr_ta = reg_in.wr;
        end else if (reg_in.addr == addr_brownout_ctrl_first) begin
            wr_c0 = reg_in.wr;
        end else if (reg_in.addr == addr_brownout_ctrl_second) begin
            wr_c1 = reg_in.wr;
        end else if (reg_in.addr == addr_power_control_flags) begin
            wr_power_control_flags = reg_in.wr;
        end else if (reg_in.addr == addr_por_disable_key) begin
            wr_por = reg_in.wr;
        end
    end

    assign protected_wr = (wr_c0 | wr_c1 | wr_por) & s_q.ta_open;

    // ******************************
    // filter and sampling selection
    // ******************************
    always_comb begin
        if (fast_clock_source_in && !power_down_in && s_q.lp_sel == lp_normal) begin
            flt_limit = 6'(filter_fast_cycles - 1);
            flt_step  = 1'b1;
        end else begin
            flt_limit = 6'(filter_slow_cycles - 1);
            flt_step  = slow_osc_tick_in;
        end
        case (lp_mode_t'(s_q.lp_sel))
            lp_mode1: lp_limit = 8'(lp1_slow_cycles - 1);
            lp_mode2: lp_limit = 8'(lp2_slow_cycles - 1);
            lp_mode3: lp_limit = 8'(lp3_slow_cycles - 1);
            default:  lp_limit = 8'h00;
        endcase
    end

    assign valid      = s_q.den && s_q.settle == 2'h0;
    assign raw_level  = s_q.lp_sel == lp_normal ? supply_below_in : s_q.sampled;
    assign prev_level = s_q.brownout_level_status;

    // ******************************
    // next state
    // ******************************
    always_comb begin
        s_d            = s_q;
        s_d.irq        = 1'b0;
        s_d.bo_reset   = 1'b0;
        s_d.sample_now = 1'b0;

        // timed access: aa then 55 opens a short window
        if (s_q.ta_open) begin
            s_d.ta_count = s_q.ta_count - 3'h1;
            if (s_q.ta_count == 3'h0 || protected_wr) begin
                s_d.ta_open = 1'b0;
            end
        end
        if (wr_ta) begin
            s_d.ta_stage = reg_in.wdata == ta_key_first;
            if (s_q.ta_stage && reg_in.wdata == ta_key_second) begin
                s_d.ta_open  = 1'b1;
                s_d.ta_count = 3'(ta_window_cycles - 1);
            end
        end

        // power-on disable key
        if (wr_por && s_q.ta_open) begin
            s_d.por_armed = reg_in.wdata == por_key_first;
            if (s_q.por_armed && reg_in.wdata == por_key_second) begin
                s_d.por_en = 1'b0;
            end
        end

        if (wr_power_control_flags && !reg_in.wdata[power_control_flags_pof_bit]) begin
            s_d.power_on_flag = 1'b0;
        end

        if (wr_c0 && s_q.ta_open) begin
            s_d.den    = reg_in.wdata[c0_den_bit];
            s_d.lvl    = reg_in.wdata[c0_lvl_lo +: 2];
            s_d.rst_en = reg_in.wdata[c0_rst_bit];
            if (!reg_in.wdata[c0_bof_bit]) begin
                s_d.brownout_event_flag = 1'b0;
            end
            if (!reg_in.wdata[c0_brownout_reset_flag_bit]) begin
                s_d.brownout_reset_flag = 1'b0;
            end
            if (reg_in.wdata[c0_den_bit] && !s_q.den) begin
                s_d.settle = 2'(settle_slow_cycles);
            end
        end
        if (wr_c1 && s_q.ta_open) begin
            s_d.lp_sel = reg_in.wdata[c1_lp_lo +: 2];
            s_d.flt    = reg_in.wdata[c1_flt_bit];
        end

        if (s_q.settle != 2'h0 && slow_osc_tick_in) begin
            s_d.settle = s_q.settle - 2'h1;
        end

        // periodic sampling in low-power mode
        if (s_q.lp_sel != lp_normal && slow_osc_tick_in) begin
            if (s_q.lp_count >= lp_limit) begin
                s_d.lp_count   = 8'h00;
                s_d.sample_now = 1'b1;
            end else begin
                s_d.lp_count = s_q.lp_count + 8'h01;
            end
        end
        if (s_q.sample_now) begin
            s_d.sampled = supply_below_in;
        end

        // noise filter: power-down keeps the slow filter even when software bypasses it
        if (!s_q.flt && !power_down_in) begin
            s_d.filtered  = raw_level;
            s_d.flt_count = 6'h00;
        end else if (raw_level == s_q.filtered) begin
            s_d.flt_count = 6'h00;
        end else if (flt_step) begin
            if (s_q.flt_count >= flt_limit) begin
                s_d.filtered  = raw_level;
                s_d.flt_count = 6'h00;
            end else begin
                s_d.flt_count = s_q.flt_count + 6'h01;
            end
        end

        // crossings
        if (!valid) begin
            s_d.brownout_level_status = 1'b0;
        end else begin
            s_d.brownout_level_status = s_q.filtered;
            if (s_q.filtered != prev_level) begin
                if (s_q.filtered && s_q.rst_en) begin
                    s_d.bo_reset      = 1'b1;
                    s_d.reset_pending = 1'b1;
                end else begin
                    s_d.brownout_event_flag = 1'b1;
                    s_d.irq = 1'b1;
                end
            end
        end

        // register read data
        s_d.rdata = 8'h00;
        if (reg_in.addr == addr_power_control_flags) begin
            s_d.rdata[power_control_flags_pof_bit] = s_q.power_on_flag;
        end else if (reg_in.addr == addr_brownout_ctrl_first) begin
            s_d.rdata = {s_q.den, 1'b0, s_q.lvl, s_q.brownout_event_flag, s_q.rst_en, s_q.brownout_reset_flag, s_q.brownout_level_status};
        end else if (reg_in.addr == addr_brownout_ctrl_second) begin
            s_d.rdata = {5'h00, s_q.lp_sel, s_q.flt};
        end
    end

    // ******************************
    // state register
    // ******************************
    always_ff @(posedge clock_in) begin
        if (reset_in) begin
            s_q           <= '0;
            s_q.power_on_flag       <= 1'b0;
            s_q.por_en    <= 1'b1;
            s_q.den       <= config_default[cfg_den_bit];
            s_q.lvl       <= config_default[cfg_lvl_lo +: 2];
            s_q.rst_en    <= config_default[cfg_rst_bit];
            s_q.lp_sel    <= lp_select_reset;
            s_q.flt       <= filter_reset;
            s_q.settle    <= 2'(settle_slow_cycles);
        end else if (power_on_reset_in) begin
            s_q        <= '0;
            s_q.power_on_flag    <= 1'b1;
            s_q.por_en <= 1'b1;
            s_q.den    <= boot_config_in[cfg_den_bit];
            s_q.lvl    <= boot_config_in[cfg_lvl_lo +: 2];
            s_q.rst_en <= boot_config_in[cfg_rst_bit];
            s_q.lp_sel <= lp_select_reset;
            s_q.flt    <= filter_reset;
            s_q.settle <= 2'(settle_slow_cycles);
        end else if (s_q.reset_pending) begin
            // brown-out reset: power-on flag survives, event flag clears, run-time fields reload
            s_q            <= '0;
            s_q.power_on_flag        <= s_q.power_on_flag;
            s_q.por_en     <= s_q.por_en;
            s_q.brownout_reset_flag       <= 1'b1;
            s_q.den        <= boot_config_in[cfg_den_bit];
            s_q.lvl        <= boot_config_in[cfg_lvl_lo +: 2];
            s_q.rst_en     <= boot_config_in[cfg_rst_bit];
            s_q.lp_sel     <= lp_select_reset;
            s_q.flt        <= filter_reset;
            s_q.brownout_level_status        <= s_q.brownout_level_status;
            s_q.filtered   <= s_q.filtered;
        end else begin
            s_q <= s_d;
        end
    end

    assign rdata_out          = s_q.rdata;
    assign por_enable_out     = s_q.por_en;
    assign brownout_irq_out   = s_q.irq;
    assign brownout_reset_out = s_q.bo_reset;
    assign detector_power_out = s_q.den;
    assign trip_level_out     = s_q.lvl;

endmodule

`default_nettype wire

// ===== rtl/power_monitor_pkg.sv
// package: register map, field layout, reset values and timing of the power monitor
package power_monitor_pkg;

    // ******************************
    // register addresses
    // ******************************
    localparam logic [7:0] addr_power_control_flags  = 8'h87;
    localparam logic [7:0] addr_timed_access_key     = 8'hc7;
    localparam logic [7:0] addr_brownout_ctrl_first  = 8'ha3;
    localparam logic [7:0] addr_brownout_ctrl_second = 8'hab;
    localparam logic [7:0] addr_por_disable_key      = 8'hfd;

    // ******************************
    // key values
    // ******************************
    localparam logic [7:0] ta_key_first   = 8'haa;
    localparam logic [7:0] ta_key_second  = 8'h55;
    localparam logic [7:0] por_key_first  = 8'h5a;
    localparam logic [7:0] por_key_second = 8'ha5;

    // ******************************
    // field positions
    // ******************************
    localparam int power_control_flags_pof_bit   = 4;
    localparam int cfg_den_bit    = 7;
    localparam int cfg_lvl_hi     = 6;
    localparam int cfg_lvl_lo     = 4;
    localparam int cfg_rst_bit    = 2;
    localparam int c0_den_bit     = 7;
    localparam int c0_lvl_hi      = 6;
    localparam int c0_lvl_lo      = 4;
    localparam int c0_bof_bit     = 3;
    localparam int c0_rst_bit     = 2;
    localparam int c0_brownout_reset_flag_bit    = 1;
    localparam int c0_bos_bit     = 0;
    localparam int c1_lp_hi       = 2;
    localparam int c1_lp_lo       = 1;
    localparam int c1_flt_bit     = 0;

    // ******************************
    // reset values
    // ******************************
    localparam logic [7:0] config_default     = 8'hff;
    localparam logic [7:0] power_control_flags_other_reset   = 8'h00;
    localparam logic [1:0] lp_select_reset    = 2'h0;
    localparam logic       filter_reset       = 1'b1;

    // ******************************
    // timing
    // ******************************
    localparam int ta_window_cycles    = 4;
    localparam int settle_slow_cycles  = 3;
    localparam int filter_fast_cycles  = 32;
    localparam int filter_slow_cycles  = 2;
    localparam int slow_osc_hz         = 10000;
    localparam real lp1_period_ms      = 1.6;
    localparam real lp2_period_ms      = 6.4;
    localparam real lp3_period_ms      = 25.6;
    localparam int lp1_slow_cycles = int'(lp1_period_ms * slow_osc_hz / 1000.0);
    localparam int lp2_slow_cycles = int'(lp2_period_ms * slow_osc_hz / 1000.0);
    localparam int lp3_slow_cycles = int'(lp3_period_ms * slow_osc_hz / 1000.0);

    typedef enum logic [1:0] {
        lp_normal,
        lp_mode1,
        lp_mode2,
        lp_mode3
    } lp_mode_t;

    // register access port carrier
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } reg_access_t;

endpackage

// ===== test/power_monitor_properties.sv
// checker: port relations of the power monitor control
`timescale 1ns/1ns
`default_nettype none
module power_monitor_properties
    import power_monitor_pkg::*;
(
    input wire logic        clock_in,
    input wire logic        reset_in,
    input wire logic        power_on_reset_in,
    input wire logic [7:0]  boot_config_in,
    input wire reg_access_t reg_in,
    input wire logic [7:0]  rdata_out,
    input wire logic        por_enable_out,
    input wire logic        brownout_irq_out,
    input wire logic        brownout_reset_out,
    input wire logic        detector_power_out,
    input wire logic [1:0]  trip_level_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (reset_in);

    chk_reset_state: assert property (
        $fell(reset_in) |-> por_enable_out && rdata_out == 8'h00
            && detector_power_out && trip_level_out == 2'h3)
        else $error("state after reset wrong");
    chk_pulse_quiet: assert property (
        $fell(reset_in) |-> !brownout_irq_out && !brownout_reset_out)
        else $error("pulse right after reset");
    chk_por_key: assert property (
        $fell(por_enable_out) |-> $past(reg_in.wr)
            && $past(reg_in.addr) == addr_por_disable_key
            && $past(reg_in.wdata) == por_key_second)
        else $error("power-on reset disabled without second key");
    chk_irq_xor_rst: assert property (
        !(brownout_irq_out && brownout_reset_out))
        else $error("interrupt and reset together");
    chk_irq_single: assert property (
        brownout_irq_out |=> !brownout_irq_out)
        else $error("interrupt longer than one cycle");
    chk_rst_single: assert property (
        brownout_reset_out |=> !brownout_reset_out)
        else $error("reset request longer than one cycle");
    chk_por_load: assert property (
        power_on_reset_in |=> trip_level_out == $past(boot_config_in[5:4])
            && detector_power_out == $past(boot_config_in[7]))
        else $error("config not loaded on power-on reset");
    chk_settle_quiet: assert property (
        $rose(detector_power_out) |-> !brownout_irq_out [*8])
        else $error("event during settle time");
endmodule
`default_nettype wire

// ===== test/supply_partner.sv
// partner: comparator output and slow oscillator tick source
`timescale 1ns/1ns
`default_nettype none
module supply_partner #(
    parameter int tick_cycles = 10
) (
    input  wire logic clock_in,
    input  wire logic low_req_in,
    output var logic  slow_tick_out = 1'b0,
    output var logic  supply_below_out = 1'b0
);
    int cnt_q = 0;
    always @(posedge clock_in) begin
        cnt_q <= (cnt_q == tick_cycles - 1) ? 0 : cnt_q + 1;
        slow_tick_out <= (cnt_q == 0);
        supply_below_out <= low_req_in;
    end
endmodule
`default_nettype wire

// ===== test/test_power_monitor_control.sv
// testbench: power monitor control with comparator partner and register traffic
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin fails++; \
    $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module test_power_monitor_control;
    import power_monitor_pkg::*;
    logic        clock_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        power_on_reset_in = 1'b0;
    logic        fast_src = 1'b1, pdown = 1'b0;
    logic        low_req = 1'b0;
    logic [7:0]  boot_config_in = 8'hff;
    reg_access_t reg_in = '0;
    logic        slow_tick, supply_below, seen_q = 1'b0;
    logic [7:0]  rdata_out, cfg, c0;
    logic        por_enable_out, brownout_irq_out, brownout_reset_out, detector_power_out;
    logic [1:0]  trip_level_out;
    logic [15:0] notes[$];
    int          fails = 0, checks_done = 0, cycles = 0, irqs = 0, rsts = 0;

    initial forever #4 clock_in = ~clock_in;

    power_monitor_control DUT (.clock_in, .reset_in, .power_on_reset_in,
        .slow_osc_tick_in(slow_tick), .fast_clock_source_in(fast_src), .power_down_in(pdown),
        .supply_below_in(supply_below), .boot_config_in, .reg_in, .rdata_out,
        .por_enable_out, .brownout_irq_out, .brownout_reset_out, .detector_power_out,
        .trip_level_out);
    supply_partner partner (.clock_in, .low_req_in(low_req), .slow_tick_out(slow_tick),
        .supply_below_out(supply_below));

    task automatic finish_test();
        $display("checks_done=%0d fails=%0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge clock_in) begin
        seen_q <= reg_in.rd;
        cycles <= cycles + 1;
        irqs <= irqs + int'(brownout_irq_out);
        rsts <= rsts + int'(brownout_reset_out);
        if (cycles == 60000) begin
            fails++;
            finish_test();
        end
    end
    // read data lands one cycle after the address
    always @(negedge clock_in) if (seen_q) begin
        `CHK(rdata_out & notes[0][15:8], notes[0][7:0])
        void'(notes.pop_front());
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_in);
        reg_in <= '{1'b1, 1'b0, a, d};
        @(posedge clock_in);
        reg_in.wr <= 1'b0;
    endtask
    task automatic twr(input logic [7:0] a, input logic [7:0] d);
        wr(addr_timed_access_key, ta_key_first);
        wr(addr_timed_access_key, ta_key_second);
        wr(a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clock_in);
        notes.push_back({m, e});
        reg_in <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge clock_in);
        reg_in.rd <= 1'b0;
    endtask
    // move the supply, then count interrupts and reset requests
    task automatic supply(input logic lo, input int lim, input int ni, input int nr);
        int i0;
        int r0;
        i0 = irqs;
        r0 = rsts;
        @(posedge clock_in);
        low_req <= lo;
        repeat (lim) @(posedge clock_in) if (irqs + rsts != i0 + r0) break;
        repeat (4) @(posedge clock_in);
        `CHK(irqs - i0, ni)
        `CHK(rsts - r0, nr)
    endtask

    initial begin
        void'($urandom(32'h4b5c));
        repeat (16) @(posedge clock_in);
        reset_in <= 1'b0;
        rd(addr_power_control_flags, 8'h10, 8'h00);
        rd(addr_brownout_ctrl_first, 8'hff, 8'hb4);
        rd(addr_brownout_ctrl_second, 8'h07, 8'h01);
        cfg = 8'h80 | (8'($urandom) & 8'h34);
        @(posedge clock_in);
        boot_config_in <= cfg;
        power_on_reset_in <= 1'b1;
        @(posedge clock_in);
        power_on_reset_in <= 1'b0;
        rd(addr_power_control_flags, 8'h10, 8'h10);
        rd(addr_brownout_ctrl_first, 8'hff, cfg & 8'hb4);
        wr(addr_power_control_flags, 8'h00);
        rd(addr_power_control_flags, 8'h10, 8'h00);
        wr(addr_brownout_ctrl_first, 8'h00);
        rd(addr_brownout_ctrl_first, 8'hff, cfg & 8'hb4);
        c0 = 8'h80 | (8'($urandom) & 8'h30);
        twr(addr_brownout_ctrl_first, c0);
        wr(addr_brownout_ctrl_first, 8'h00);
        rd(addr_brownout_ctrl_first, 8'hff, c0);
        `CHK(trip_level_out, c0[5:4])
        for (int m = 0; m < 4; m++) begin
            twr(addr_brownout_ctrl_second, 8'(m << 1));
            rd(addr_brownout_ctrl_second, 8'h07, 8'(m << 1));
            supply(1'b1, 3000, 1, 0);
            rd(addr_brownout_ctrl_first, 8'h09, 8'h09);
            supply(1'b0, 3000, 1, 0);
            rd(addr_brownout_ctrl_first, 8'h09, 8'h08);
            twr(addr_brownout_ctrl_first, c0);
        end
        twr(addr_brownout_ctrl_second, 8'h00);
        supply(1'b1, 50, 1, 0);
        twr(addr_brownout_ctrl_first, c0);
        rd(addr_brownout_ctrl_first, 8'h09, 8'h01);
        supply(1'b1, 50, 0, 0);
        supply(1'b0, 50, 1, 0);
        twr(addr_brownout_ctrl_second, 8'h01);
        supply(1'b1, 20, 0, 0);
        supply(1'b0, 60, 0, 0);
        supply(1'b1, 80, 1, 0);
        supply(1'b0, 80, 1, 0);
        fast_src <= 1'b0;
        supply(1'b1, 22, 1, 0);
        fast_src <= 1'b1;
        pdown <= 1'b1;
        twr(addr_brownout_ctrl_second, 8'h00);
        supply(1'b0, 5, 0, 0);
        supply(1'b0, 30, 1, 0);
        pdown <= 1'b0;
        twr(addr_brownout_ctrl_first, c0 & 8'h7f);
        supply(1'b1, 80, 0, 0);
        rd(addr_brownout_ctrl_first, 8'h01, 8'h00);
        twr(addr_brownout_ctrl_first, c0);
        supply(1'b1, 14, 0, 0);
        supply(1'b1, 40, 1, 0);
        twr(addr_brownout_ctrl_first, c0 & 8'h7f);
        supply(1'b0, 80, 0, 0);
        twr(addr_brownout_ctrl_first, c0);
        supply(1'b0, 60, 0, 0);
        twr(addr_brownout_ctrl_first, c0 | 8'h04);
        supply(1'b1, 80, 0, 1);
        rd(addr_brownout_ctrl_first, 8'h02, 8'h02);
        twr(addr_brownout_ctrl_first, cfg & 8'hb4);
        rd(addr_brownout_ctrl_first, 8'h02, 8'h00);
        wr(addr_por_disable_key, por_key_first);
        twr(addr_por_disable_key, por_key_second);
        @(negedge clock_in);
        `CHK(por_enable_out, 1'b1)
        twr(addr_por_disable_key, por_key_first);
        twr(addr_por_disable_key, 8'h00);
        twr(addr_por_disable_key, por_key_second);
        @(negedge clock_in);
        `CHK(por_enable_out, 1'b1)
        twr(addr_por_disable_key, por_key_first);
        twr(addr_por_disable_key, por_key_second);
        @(negedge clock_in);
        `CHK(por_enable_out, 1'b0)
        repeat (3) @(posedge clock_in);
        finish_test();
    end
endmodule
bind power_monitor_control power_monitor_properties chk (.clock_in, .reset_in,
    .power_on_reset_in, .boot_config_in, .reg_in, .rdata_out, .por_enable_out,
    .brownout_irq_out, .brownout_reset_out, .detector_power_out, .trip_level_out);
`default_nettype wire
